// *** hw/slb_consts.vh ***
// Purpose: shared constants of the status LED blink indicator
// Assumes: 20 MHz system clock
// Notes:   times are kept in their own unit; cycle counts derive from them
`ifndef SLB_CONSTS_VH
`define SLB_CONSTS_VH

// system clock
`define SLB_CLK_KHZ        20000
`define SLB_CLK_HZ         20000000

// blink half periods in milliseconds (on time equals off time)
`define SLB_T_VSLOW_MS     1000
`define SLB_T_SLOW_MS      500
`define SLB_T_MED_MS       250
`define SLB_T_FAST_MS      100

// network line rate and manchester half bit
`define SLB_NET_BPS        78000
`define SLB_NET_HALF_CYC   (`SLB_CLK_HZ / (2 * `SLB_NET_BPS))
`define SLB_NET_BITS       8

// register offsets (byte addresses)
`define SLB_REG_COND       8'h00
`define SLB_REG_STAT       8'h04
`define SLB_REG_TXDATA     8'h08

// condition register bit positions
`define SLB_COND_NOT_RUN   0
`define SLB_COND_NORMAL    1
`define SLB_COND_ALARM     2
`define SLB_COND_DOWNLOAD  3
`define SLB_COND_CFG_LOST  4
`define SLB_COND_FW_LOAD   5
`define SLB_COND_MANUAL    6
`define SLB_COND_W         7
`define SLB_COND_RESET     7'h00

// status register fields
`define SLB_STAT_PAT_LSB   0
`define SLB_STAT_PAT_MSB   2
`define SLB_STAT_LED       3
`define SLB_STAT_TX_BUSY   4

// pattern codes
`define SLB_PAT_OFF        3'h0
`define SLB_PAT_STEADY     3'h1
`define SLB_PAT_VSLOW      3'h2
`define SLB_PAT_SLOW       3'h3
`define SLB_PAT_MED        3'h4
`define SLB_PAT_FAST       3'h5

`endif

// *** hw/slb_blink_timer.v ***
// Purpose: 50% duty phase generator for the status LED
// Assumes: half_cyc is at least 1 and held while no restart is given
// Notes:   restart puts the phase into the lit half, count from zero
`timescale 1ns/1ns
`default_nettype none

module slb_blink_timer #(
  parameter CW = 25
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          restart,
  input  wire [CW-1:0] half_cyc,
  output reg           phase_q
);

  reg [CW-1:0] count_q;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= {CW{1'b0}};
      phase_q <= 1'b1;
    end
    else if (restart)
    begin
      count_q <= {CW{1'b0}};
      phase_q <= 1'b1;
    end
    else if (count_q == half_cyc - {{(CW-1){1'b0}}, 1'b1})
    begin
      count_q <= {CW{1'b0}};
      phase_q <= ~phase_q;
    end
    else
    begin
      count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule // slb_blink_timer

`default_nettype wire

// *** hw/slb_status_led.v ***
// Purpose: picks a blink pattern for the front-panel status LED and sends
//          manchester coded bytes on the network line
// Assumes: condition inputs and register strobes are synchronous to CLOCK
// Notes:   conditions from pins and from the condition register are ORed
//
// Contract
// - not running gives steady lit LED
// - normal operation blinks 1 s on, 1 s off
// - alarm, download, lost config blink 0.5 s
// - firmware loading blinks 0.25 s on/off
// - manual mode blinks 0.10 s on/off
// - network sends manchester data at 78 kbit/s
`timescale 1ns/1ns
`default_nettype none
`include "slb_consts.vh"

module slb_status_led #(
  parameter CW        = 25,
  parameter VSLOW_CYC = `SLB_T_VSLOW_MS * `SLB_CLK_KHZ,
  parameter SLOW_CYC  = `SLB_T_SLOW_MS * `SLB_CLK_KHZ,
  parameter MED_CYC   = `SLB_T_MED_MS * `SLB_CLK_KHZ,
  parameter FAST_CYC  = `SLB_T_FAST_MS * `SLB_CLK_KHZ
) (
  input  wire        CLOCK,
  input  wire        RSTN,
  input  wire        COND_NOT_RUNNING,
  input  wire        COND_NORMAL,
  input  wire        COND_ALARM,
  input  wire        COND_DOWNLOAD,
  input  wire        COND_CFG_LOST,
  input  wire        COND_FW_LOADING,
  input  wire        COND_MANUAL,
  input  wire [7:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [31:0] REG_RDATA,
  output reg         STATUS_LED,
  output reg         NET_TX_DO,
  output reg         NET_TX_OE
);

  localparam [CW-1:0] VSLOW_HALF = VSLOW_CYC[CW-1:0];
  localparam [CW-1:0] SLOW_HALF  = SLOW_CYC[CW-1:0];
  localparam [CW-1:0] MED_HALF   = MED_CYC[CW-1:0];
  localparam [CW-1:0] FAST_HALF  = FAST_CYC[CW-1:0];

  localparam integer  NET_HALF_I = `SLB_NET_HALF_CYC;
  localparam [7:0]    NET_HALF   = NET_HALF_I[7:0];
  localparam [2:0]    NET_LAST   = 3'h7;

  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;

  reg  [`SLB_COND_W-1:0] cond_q;
  wire [`SLB_COND_W-1:0] cond_all;
  reg  [2:0]             pat_d;
  reg  [2:0]             pat_q;
  reg  [CW-1:0]          half_sel;
  wire                   phase;
  reg                    led_d;

  reg                    tx_state_q;
  reg  [7:0]             tx_shift_q;
  reg  [2:0]             tx_bit_q;
  reg                    tx_second_q;
  reg  [7:0]             tx_cnt_q;
  wire                   tx_start;
  wire                   half_done;

  assign cond_all = cond_q | {COND_MANUAL, COND_FW_LOADING, COND_CFG_LOST,
                              COND_DOWNLOAD, COND_ALARM, COND_NORMAL,
                              COND_NOT_RUNNING};

  // fixed priority so that only one pattern ever shows
  always @*
  begin
    if (cond_all[`SLB_COND_NOT_RUN])
      pat_d = `SLB_PAT_STEADY;
    else if (cond_all[`SLB_COND_FW_LOAD])
      pat_d = `SLB_PAT_MED;
    else if (cond_all[`SLB_COND_MANUAL])
      pat_d = `SLB_PAT_FAST;
    else if (cond_all[`SLB_COND_ALARM] | cond_all[`SLB_COND_DOWNLOAD] |
             cond_all[`SLB_COND_CFG_LOST])
      pat_d = `SLB_PAT_SLOW;
    else if (cond_all[`SLB_COND_NORMAL])
      pat_d = `SLB_PAT_VSLOW;
    else
      pat_d = `SLB_PAT_OFF;
  end

  always @*
  begin
    case (pat_q)
      `SLB_PAT_VSLOW: half_sel = VSLOW_HALF;
      `SLB_PAT_SLOW:  half_sel = SLOW_HALF;
      `SLB_PAT_MED:   half_sel = MED_HALF;
      `SLB_PAT_FAST:  half_sel = FAST_HALF;
      default:        half_sel = FAST_HALF;
    endcase
  end

  // a pattern change restarts the timer so each blinking pattern begins with a full lit half
  slb_blink_timer #(
    .CW (CW)
  ) u_timer (
    .clk      (CLOCK),
    .rst_n    (RSTN),
    .restart  (pat_d != pat_q),
    .half_cyc (half_sel),
    .phase_q  (phase)
  );

  always @*
  begin
    case (pat_q)
      `SLB_PAT_OFF:    led_d = 1'b0;
      `SLB_PAT_STEADY: led_d = 1'b1;
      default:         led_d = phase;
    endcase
  end

  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pat_q      <= `SLB_PAT_OFF;
      STATUS_LED <= 1'b0;
    end
    else
    begin
      pat_q      <= pat_d;
      STATUS_LED <= led_d;
    end
  end

  // register port
  assign tx_start = REG_WR && (REG_ADDR == `SLB_REG_TXDATA) && (tx_state_q == TX_IDLE);

  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cond_q    <= `SLB_COND_RESET;
      REG_RDATA <= 32'h00000000;
    end
    else
    begin
      if (REG_WR && (REG_ADDR == `SLB_REG_COND))
        cond_q <= REG_WDATA[`SLB_COND_W-1:0];
      REG_RDATA <= 32'h00000000;
      if (REG_RD)
      begin
        case (REG_ADDR)
          `SLB_REG_COND:
            REG_RDATA <= {{(32-`SLB_COND_W){1'b0}}, cond_q};
          `SLB_REG_STAT:
            REG_RDATA <= {27'h0, (tx_state_q == TX_SEND), STATUS_LED, pat_q};
          default:
            REG_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // manchester transmitter, msb first; first half carries the inverted bit,
  // second half the bit, so every bit has a mid-cell transition
  assign half_done = (tx_cnt_q == NET_HALF - 8'h01);

  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tx_state_q  <= TX_IDLE;
      tx_shift_q  <= 8'h00;
      tx_bit_q    <= 3'h0;
      tx_second_q <= 1'b0;
      tx_cnt_q    <= 8'h00;
      NET_TX_DO   <= 1'b0;
      NET_TX_OE   <= 1'b0;
    end
    else
    begin
      case (tx_state_q)
        TX_IDLE:
        begin
          NET_TX_OE <= 1'b0;
          NET_TX_DO <= 1'b0;
          if (tx_start)
          begin
            tx_state_q  <= TX_SEND;
            tx_shift_q  <= REG_WDATA[7:0];
            tx_bit_q    <= 3'h0;
            tx_second_q <= 1'b0;
            tx_cnt_q    <= 8'h00;
            NET_TX_OE   <= 1'b1;
            NET_TX_DO   <= ~REG_WDATA[7];
          end
        end
        TX_SEND:
        begin
          if (!half_done)
            tx_cnt_q <= tx_cnt_q + 8'h01;
          else
          begin
            tx_cnt_q <= 8'h00;
            if (!tx_second_q)
            begin
              tx_second_q <= 1'b1;
              NET_TX_DO   <= tx_shift_q[7];
            end
            else if (tx_bit_q == NET_LAST)
            begin
              tx_state_q <= TX_IDLE;
              NET_TX_OE  <= 1'b0;
              NET_TX_DO  <= 1'b0;
            end
            else
            begin
              tx_second_q <= 1'b0;
              tx_bit_q    <= tx_bit_q + 3'h1;
              tx_shift_q  <= {tx_shift_q[6:0], 1'b0};
              NET_TX_DO   <= ~tx_shift_q[6];
            end
          end
        end
        default:
          tx_state_q <= TX_IDLE;
      endcase
    end
  end

endmodule // slb_status_led

`default_nettype wire

// *** tb/slb_status_led_asserts.sv ***
// Purpose: port timing checks of the status LED block
// Assumes: cond register clear while pins select the fast or medium rate
// Notes:   a run is judged only once pins have been still for two half periods plus four cycles
`timescale 1ns/1ns
`default_nettype none
module slb_status_led_asserts #(
  parameter MED_CYC  = 10,
  parameter FAST_CYC = 4
) (
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire logic        COND_NOT_RUNNING,
  input wire logic        COND_FW_LOADING,
  input wire logic        COND_MANUAL,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic        STATUS_LED,
  input wire logic        NET_TX_DO,
  input wire logic        NET_TX_OE
);
  int         oe_n_q;
  int         led_n_q;
  int         pin_n_q;
  logic       led_q;
  logic [2:0] pin_q;
  wire  [2:0] pin_d = {COND_NOT_RUNNING, COND_FW_LOADING, COND_MANUAL};
  // a merged leftover run from the old pattern is shorter than this wait
  wire man_only = pin_d == 3'h1 && pin_n_q > 2 * FAST_CYC + 4;
  wire fw_only  = pin_d[2:1] == 2'h1 && pin_n_q > 2 * MED_CYC + 4;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  always @(posedge CLOCK or negedge RSTN)
    if (!RSTN)
    begin
      oe_n_q <= 0;
      led_n_q <= 0;
      pin_n_q <= 0;
      led_q <= 1'b0;
      pin_q <= 3'h0;
    end
    else
    begin
      oe_n_q <= NET_TX_OE ? oe_n_q + 1 : 0;
      led_n_q <= (STATUS_LED != led_q) ? 1 : led_n_q + 1;
      pin_n_q <= (pin_d != pin_q) ? 0 : pin_n_q + 1;
      led_q <= STATUS_LED;
      pin_q <= pin_d;
    end
  sequence mid_bit;
    NET_TX_OE && oe_n_q[7:0] == 8'h80;
  endsequence
  steady_on_a: assert property (COND_NOT_RUNNING [*3] |-> STATUS_LED)
    else $error("led not steady");
  fast_half_a: assert property ($changed(STATUS_LED) && man_only |-> led_n_q == FAST_CYC)
    else $error("fast half wrong");
  med_half_a: assert property ($changed(STATUS_LED) && fw_only |-> led_n_q == MED_CYC)
    else $error("medium half wrong");
  tx_len_a: assert property ($fell(NET_TX_OE) |-> oe_n_q == 2048)
    else $error("byte length wrong");
  edge_grid_a: assert property ($changed(NET_TX_DO) && NET_TX_OE && $past(NET_TX_OE)
    |-> oe_n_q[6:0] == 7'h00)
    else $error("line edge off grid");
  mid_flip_a: assert property (mid_bit |-> $changed(NET_TX_DO))
    else $error("no mid bit edge");
  idle_low_a: assert property (!NET_TX_OE |-> !NET_TX_DO)
    else $error("line not idle");
  rd_zero_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not cleared");
endmodule // slb_status_led_asserts
bind slb_status_led slb_status_led_asserts #(.MED_CYC(MED_CYC), .FAST_CYC(FAST_CYC)) chk_u (
  .CLOCK, .RSTN, .COND_NOT_RUNNING, .COND_FW_LOADING, .COND_MANUAL, .REG_RD,
  .REG_RDATA, .STATUS_LED, .NET_TX_DO, .NET_TX_OE);
`default_nettype wire

// *** tb/slb_led_obs.sv ***
// Purpose: front-panel LED seen as lengths of its lit and dark runs
// Assumes: led changes only at clock edges
// Notes:   a length is posted when its run ends
`timescale 1ns/1ns
`default_nettype none
module slb_led_obs (
  input  wire logic clk,
  input  wire logic led,
  output int        on_len,
  output int        off_len
);
  int   run = 0;
  logic last = 1'b0;
  always @(posedge clk)
  begin
    if (led !== last)
    begin
      if (last)
        on_len <= run;
      else
        off_len <= run;
      run <= 1;
    end
    else
      run <= run + 1;
    last <= led;
  end
endmodule // slb_led_obs
`default_nettype wire

// *** tb/tb_slb_status_led.sv ***
// Purpose: self-checking bench of the status LED block
// Assumes: short blink counts 40, 20, 10, 4 cycles
// Notes:   rows cover pattern choice, hand tests cover the rest
`timescale 1ns/1ns
`default_nettype none
`define CK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_slb_status_led;
  logic        CLOCK = 1'b0;
  logic        RSTN = 1'b0;
  logic        COND_NOT_RUNNING = 0, COND_NORMAL = 0, COND_ALARM = 0, COND_DOWNLOAD = 0;
  logic        COND_CFG_LOST = 0, COND_FW_LOADING = 0, COND_MANUAL = 0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
  logic        REG_WR = 0, REG_RD = 0, STATUS_LED, NET_TX_DO, NET_TX_OE;
  logic [7:0]  b = 8'hA5;
  int          on_len, off_len, n_mismatch = 0, checked = 0;
  logic [6:0]  rc [9] = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h60, 7'h44, 7'h06};
  int          rh [9] = '{40, 20, 20, 20, 10, 4, 10, 4, 20};
  slb_status_led #(.VSLOW_CYC(40), .SLOW_CYC(20), .MED_CYC(10), .FAST_CYC(4)) dut_u (
    .CLOCK, .RSTN, .COND_NOT_RUNNING, .COND_NORMAL, .COND_ALARM, .COND_DOWNLOAD,
    .COND_CFG_LOST, .COND_FW_LOADING, .COND_MANUAL, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .STATUS_LED, .NET_TX_DO, .NET_TX_OE);
  slb_led_obs obs_u (.clk(CLOCK), .led(STATUS_LED), .on_len, .off_len);
  initial forever #25 CLOCK = ~CLOCK;
  task setp(input logic [6:0] c);
    @(posedge CLOCK);
    {COND_MANUAL, COND_FW_LOADING, COND_CFG_LOST, COND_DOWNLOAD, COND_ALARM,
      COND_NORMAL, COND_NOT_RUNNING} <= c;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #1000000;
    n_mismatch++;
    close_out;
  end
  initial
  begin
    repeat (11) @(posedge CLOCK);
    #1 `CK({STATUS_LED, NET_TX_DO, NET_TX_OE, REG_RDATA}, 35'h0)
    @(posedge CLOCK);
    RSTN <= 1'b1;
    rd(8'h00);
    `CK(d, 32'h0)
    $display("reset test done");
    for (int i = 0; i < 9; i++)
    begin
      setp(rc[i]);
      repeat (5 * rh[i] + 8) @(posedge CLOCK);
      #1 `CK({on_len, off_len}, {rh[i], rh[i]})
      $display("row %0d done", i);
    end
    setp(7'h41);
    repeat (20) @(posedge CLOCK);
    #1 `CK(STATUS_LED, 1'b1)
    rd(8'h04);
    `CK(d[2:0], 3'h1)
    $display("steady test done");
    setp(7'h00);
    wr(8'h00, 32'h2);
    repeat (208) @(posedge CLOCK);
    #1 `CK({on_len, off_len}, {32'd40, 32'd40})
    rd(8'h04);
    `CK(d & 32'h17, 32'h02)
    rd(8'h00);
    `CK(d, 32'h2)
    rd(8'h0C);
    `CK(d, 32'h0)
    wr(8'h00, 32'h0);
    $display("register test done");
    wr(8'h08, {24'h0, b});
    wr(8'h08, 32'h0);
    rd(8'h04);
    `CK(d & 32'h17, 32'h10)
    repeat (59) @(posedge CLOCK);
    for (int k = 0; k < 16; k++)
    begin
      #1 `CK(NET_TX_DO, k[0] ? b[7 - k / 2] : ~b[7 - k / 2])
      repeat (128) @(posedge CLOCK);
    end
    #1 `CK(NET_TX_OE, 1'b0)
    `CK(STATUS_LED, 1'b0)
    $display("line test done");
    // reset in mid blink must clear the led and the condition register
    wr(8'h00, 32'h40);
    repeat (3) @(posedge CLOCK);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    #1 `CK({STATUS_LED, NET_TX_DO, NET_TX_OE, REG_RDATA}, 35'h0)
    @(posedge CLOCK);
    RSTN <= 1'b1;
    rd(8'h00);
    `CK(d, 32'h0)
    $display("mid reset test done");
    close_out;
  end
endmodule // tb_slb_status_led
`default_nettype wire
